// [include/pcr_pkg.sv]
// package: offsets, field positions, reset values and carriers for the port block
package pcr_pkg;

    // ------------------------------------------------------------------
    // register offsets within the configuration i/o space
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DATA_IN_A  = 8'h00;
    localparam logic [7:0] OFS_DATA_IN_B  = 8'h01;
    localparam logic [7:0] OFS_MODE_A     = 8'h02;
    localparam logic [7:0] OFS_MODE_B     = 8'h03;
    localparam logic [7:0] OFS_DOUT_A     = 8'h04;
    localparam logic [7:0] OFS_DOUT_B     = 8'h05;
    localparam logic [7:0] OFS_DIR_A      = 8'h06;
    localparam logic [7:0] OFS_DIR_B      = 8'h07;
    localparam logic [7:0] OFS_DRV_A      = 8'h08;
    localparam logic [7:0] OFS_DRV_B      = 8'h09;
    localparam logic [7:0] OFS_DATA_IN_C  = 8'h10;
    localparam logic [7:0] OFS_DATA_IN_D  = 8'h11;
    localparam logic [7:0] OFS_DOUT_C     = 8'h12;
    localparam logic [7:0] OFS_DOUT_D     = 8'h13;
    localparam logic [7:0] OFS_DIR_C      = 8'h14;
    localparam logic [7:0] OFS_DIR_D      = 8'h15;
    localparam logic [7:0] OFS_DRV_C      = 8'h16;
    localparam logic [7:0] OFS_DRV_D      = 8'h17;
    localparam logic [7:0] OFS_OMC_AB     = 8'h20;
    localparam logic [7:0] OFS_OMC_BC     = 8'h21;
    localparam logic [7:0] OFS_OMC_MASK_AB = 8'h22;
    localparam logic [7:0] OFS_OMC_MASK_BC = 8'h23;
    localparam logic [7:0] OFS_MEM_MAP    = 8'hB0;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         PERIPH_BIT     = 7;
    localparam logic [7:0] REG_RST        = 8'h00;
    localparam logic [7:0] PORT_D_MASK    = 8'h07;
    localparam logic [7:0] DRV_AB_OD_MASK = 8'hF0;
    localparam logic [7:0] DRV_AB_SL_MASK = 8'h0F;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // address-out mapping selects
    localparam logic [1:0] AMAP_GENERIC   = 2'h0;
    localparam logic [1:0] AMAP_NONMUX    = 2'h1;
    localparam logic [1:0] AMAP_TYPE_X    = 2'h2;
    localparam logic [1:0] AMAP_TYPE_Y    = 2'h3;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcr_bus_t;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] od;
        logic [7:0] fast;
    } pcr_pin_t;

endpackage : pcr_pkg

// [logic/pcr_ports.sv]
// four programmable i/o ports: configuration, data and macrocell registers
`timescale 1ns/10ps
module pcr_ports (
    // clock, reset, enable
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire logic              clk_en_i,
    // mcu register bus
    input  wire pcr_pkg::pcr_bus_t bus_i,
    output logic [7:0]             rdata_o,
    // mcu address and data bus view
    input  wire logic [15:0]       mcu_addr_i,
    input  wire logic [7:0]        mcu_data_i,
    input  wire logic              mcu_rd_cycle_i,
    input  wire logic              address_latch_strobe_i,
    output logic [7:0]             mcu_data_o,
    // configuration set at programming time
    input  wire logic [1:0]        addr_map_sel_i,
    input  wire logic              data_port_cfg_i,
    input  wire logic              test_port_cfg_i,
    input  wire logic              jtag_enable_i,
    // logic-array terms
    input  wire logic [7:0]        array_oe_a_i,
    input  wire logic [7:0]        array_oe_b_i,
    input  wire logic [7:0]        array_oe_c_i,
    input  wire logic [2:0]        array_oe_d_i,
    input  wire logic              periph_select_term_0_i,
    input  wire logic              periph_select_term_1_i,
    input  wire logic              test_port_select_term_i,
    input  wire logic [15:0]       output_macrocell_d_i,
    // pins
    input  wire logic [7:0]        pin_a_i,
    input  wire logic [7:0]        pin_b_i,
    input  wire logic [7:0]        pin_c_i,
    input  wire logic [2:0]        pin_d_i,
    output pcr_pkg::pcr_pin_t      pin_a_o,
    output pcr_pkg::pcr_pin_t      pin_b_o,
    output pcr_pkg::pcr_pin_t      pin_c_o,
    output logic [2:0]             pin_d_o,
    output logic [2:0]             pin_d_oe_o,
    output logic [2:0]             pin_d_fast_o,
    // status
    output logic                   test_port_active_o,
    output logic                   periph_mode_o,
    output logic [15:0]            addr_in_latched_o,
    output logic [15:0]            output_macrocell_o
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0]  mode_a_ff;
    logic [7:0]  mode_b_ff;
    logic [7:0]  dir_a_ff;
    logic [7:0]  dir_b_ff;
    logic [7:0]  dir_c_ff;
    logic [7:0]  dir_d_ff;
    logic [7:0]  drv_a_ff;
    logic [7:0]  drv_b_ff;
    logic [7:0]  drv_c_ff;
    logic [7:0]  drv_d_ff;
    logic [7:0]  dout_a_ff;
    logic [7:0]  dout_b_ff;
    logic [7:0]  dout_c_ff;
    logic [7:0]  dout_d_ff;
    logic [15:0] omc_ff;
    logic [15:0] omc_mask_ff;
    logic [7:0]  mem_map_ff;
    logic [15:0] addr_lat_ff;
    logic        wr;
    logic        rd;

    assign wr = clk_en_i & bus_i.wr;
    assign rd = clk_en_i & bus_i.rd;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_a_ff <= pcr_pkg::REG_RST;
            mode_b_ff <= pcr_pkg::REG_RST;
            dir_a_ff  <= pcr_pkg::REG_RST;
            dir_b_ff  <= pcr_pkg::REG_RST;
            dir_c_ff  <= pcr_pkg::REG_RST;
            dir_d_ff  <= pcr_pkg::REG_RST;
            drv_a_ff  <= pcr_pkg::REG_RST;
            drv_b_ff  <= pcr_pkg::REG_RST;
            drv_c_ff  <= pcr_pkg::REG_RST;
            drv_d_ff  <= pcr_pkg::REG_RST;
            mem_map_ff <= pcr_pkg::REG_RST;
        end else if (wr) begin
            unique case (bus_i.addr)
                pcr_pkg::OFS_MODE_A: mode_a_ff <= bus_i.wdata;
                pcr_pkg::OFS_MODE_B: mode_b_ff <= bus_i.wdata;
                pcr_pkg::OFS_DIR_A:  dir_a_ff  <= bus_i.wdata;
                pcr_pkg::OFS_DIR_B:  dir_b_ff  <= bus_i.wdata;
                pcr_pkg::OFS_DIR_C:  dir_c_ff  <= bus_i.wdata;
                // only three pins exist on port d
                pcr_pkg::OFS_DIR_D:  dir_d_ff  <= bus_i.wdata
                                        & pcr_pkg::PORT_D_MASK;
                pcr_pkg::OFS_DRV_A:  drv_a_ff  <= bus_i.wdata;
                pcr_pkg::OFS_DRV_B:  drv_b_ff  <= bus_i.wdata;
                pcr_pkg::OFS_DRV_C:  drv_c_ff  <= bus_i.wdata;
                pcr_pkg::OFS_DRV_D:  drv_d_ff  <= bus_i.wdata
                                        & pcr_pkg::PORT_D_MASK;
                pcr_pkg::OFS_MEM_MAP: mem_map_ff <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // data-out registers and macrocells
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dout_a_ff <= pcr_pkg::REG_RST;
            dout_b_ff <= pcr_pkg::REG_RST;
            dout_c_ff <= pcr_pkg::REG_RST;
            dout_d_ff <= pcr_pkg::REG_RST;
            omc_mask_ff <= {pcr_pkg::REG_RST, pcr_pkg::REG_RST};
        end else if (wr) begin
            unique case (bus_i.addr)
                pcr_pkg::OFS_DOUT_A: dout_a_ff <= bus_i.wdata;
                pcr_pkg::OFS_DOUT_B: dout_b_ff <= bus_i.wdata;
                pcr_pkg::OFS_DOUT_C: dout_c_ff <= bus_i.wdata;
                pcr_pkg::OFS_DOUT_D: dout_d_ff <= bus_i.wdata
                                        & pcr_pkg::PORT_D_MASK;
                pcr_pkg::OFS_OMC_MASK_AB: omc_mask_ff[7:0]  <= bus_i.wdata;
                pcr_pkg::OFS_OMC_MASK_BC: omc_mask_ff[15:8] <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // mcu load wins over the logic-array next state, except masked bits
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            omc_ff <= {pcr_pkg::REG_RST, pcr_pkg::REG_RST};
        end else if (clk_en_i) begin
            for (int i = 0; i < 16; i++) begin
                if (wr && !omc_mask_ff[i] &&
                    bus_i.addr == (i < 8 ? pcr_pkg::OFS_OMC_AB
                                         : pcr_pkg::OFS_OMC_BC)) begin
                    omc_ff[i] <= bus_i.wdata[i % 8];
                end else begin
                    omc_ff[i] <= output_macrocell_d_i[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // address input latch on the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_lat_ff <= {pcr_pkg::REG_RST, pcr_pkg::REG_RST};
        end else if (clk_en_i && address_latch_strobe_i) begin
            addr_lat_ff <= mcu_addr_i;
        end
    end

    // ------------------------------------------------------------------
    // pin output muxing
    // ------------------------------------------------------------------
    logic       periph_on;
    logic       psel;
    logic       data_port;
    logic       test_on;
    logic [7:0] addr_a;
    logic [7:0] addr_b;
    logic [7:0] oe_a;
    logic [7:0] oe_b;
    logic [7:0] oe_c;
    logic [7:0] val_a;
    logic [7:0] val_b;
    logic [2:0] oe_d;

    assign periph_on = mem_map_ff[pcr_pkg::PERIPH_BIT];
    assign psel      = periph_select_term_0_i | periph_select_term_1_i;
    assign data_port = data_port_cfg_i;
    assign test_on   = test_port_select_term_i | test_port_cfg_i
                       | jtag_enable_i;

    // latched address placed on nibbles by bus type
    always_comb begin
        addr_a = pcr_pkg::REG_RST;
        addr_b = pcr_pkg::REG_RST;
        unique case (addr_map_sel_i)
            pcr_pkg::AMAP_GENERIC: begin
                addr_a = addr_lat_ff[7:0];
                addr_b = addr_lat_ff[7:0];
            end
            pcr_pkg::AMAP_NONMUX: begin
                addr_b = addr_lat_ff[7:0];
            end
            pcr_pkg::AMAP_TYPE_X: begin
                addr_a = {addr_lat_ff[7:4], 4'h0};
                addr_b = {4'h0, addr_lat_ff[11:8]};
            end
            pcr_pkg::AMAP_TYPE_Y: begin
                addr_b = addr_lat_ff[15:8];
            end
        endcase
    end

    // mode bit picks data-out or latched address; software sets dir too
    assign val_a = (mode_a_ff & addr_a) | (~mode_a_ff & dout_a_ff);
    assign val_b = (mode_b_ff & addr_b) | (~mode_b_ff & dout_b_ff);
    assign oe_a  = dir_a_ff | array_oe_a_i;
    assign oe_b  = dir_b_ff | array_oe_b_i;
    assign oe_c  = dir_c_ff | array_oe_c_i;
    assign oe_d  = dir_d_ff[2:0] | array_oe_d_i;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_a_o <= '0;
            pin_b_o <= '0;
            pin_c_o <= '0;
            pin_d_o <= 3'h0;
            pin_d_oe_o <= 3'h0;
            pin_d_fast_o <= 3'h0;
            mcu_data_o <= pcr_pkg::REG_RST;
        end else if (clk_en_i) begin
            // port a: data bus, peripheral buffer or general i/o
            if (data_port) begin
                pin_a_o.dout <= mcu_data_i;
                pin_a_o.oe   <= {8{~mcu_rd_cycle_i}};
                pin_a_o.od   <= 8'h00;
                pin_a_o.fast <= 8'h00;
                mcu_data_o   <= pin_a_i;
            end else if (periph_on) begin
                pin_a_o.dout <= mcu_data_i;
                pin_a_o.oe   <= {8{psel & ~mcu_rd_cycle_i}};
                pin_a_o.od   <= 8'h00;
                pin_a_o.fast <= 8'h00;
                mcu_data_o   <= psel ? pin_a_i : 8'h00;
            end else begin
                pin_a_o.dout <= val_a;
                pin_a_o.oe   <= oe_a;
                pin_a_o.od   <= drv_a_ff & pcr_pkg::DRV_AB_OD_MASK;
                pin_a_o.fast <= drv_a_ff & pcr_pkg::DRV_AB_SL_MASK;
                mcu_data_o   <= 8'h00;
            end
            pin_b_o.dout <= val_b;
            pin_b_o.oe   <= oe_b;
            pin_b_o.od   <= drv_b_ff & pcr_pkg::DRV_AB_OD_MASK;
            pin_b_o.fast <= drv_b_ff & pcr_pkg::DRV_AB_SL_MASK;
            // test port takes port c pins; its logic lives elsewhere
            pin_c_o.dout <= test_on ? 8'h00 : dout_c_ff;
            pin_c_o.oe   <= test_on ? 8'h00 : oe_c;
            pin_c_o.od   <= drv_c_ff;
            pin_c_o.fast <= 8'h00;
            pin_d_o      <= dout_d_ff[2:0];
            pin_d_oe_o   <= oe_d;
            pin_d_fast_o <= drv_d_ff[2:0];
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = pcr_pkg::RD_UNMAPPED;
        unique case (bus_i.addr)
            pcr_pkg::OFS_DATA_IN_A: nxt_rdata = pin_a_i;
            pcr_pkg::OFS_DATA_IN_B: nxt_rdata = pin_b_i;
            pcr_pkg::OFS_DATA_IN_C: nxt_rdata = pin_c_i;
            pcr_pkg::OFS_DATA_IN_D: nxt_rdata = {5'h00, pin_d_i};
            pcr_pkg::OFS_MODE_A:    nxt_rdata = mode_a_ff;
            pcr_pkg::OFS_MODE_B:    nxt_rdata = mode_b_ff;
            pcr_pkg::OFS_DOUT_A:    nxt_rdata = dout_a_ff;
            pcr_pkg::OFS_DOUT_B:    nxt_rdata = dout_b_ff;
            pcr_pkg::OFS_DOUT_C:    nxt_rdata = dout_c_ff;
            pcr_pkg::OFS_DOUT_D:    nxt_rdata = dout_d_ff;
            pcr_pkg::OFS_DIR_A:     nxt_rdata = dir_a_ff;
            pcr_pkg::OFS_DIR_B:     nxt_rdata = dir_b_ff;
            pcr_pkg::OFS_DIR_C:     nxt_rdata = dir_c_ff;
            pcr_pkg::OFS_DIR_D:     nxt_rdata = dir_d_ff;
            pcr_pkg::OFS_DRV_A:     nxt_rdata = drv_a_ff;
            pcr_pkg::OFS_DRV_B:     nxt_rdata = drv_b_ff;
            pcr_pkg::OFS_DRV_C:     nxt_rdata = drv_c_ff;
            pcr_pkg::OFS_DRV_D:     nxt_rdata = drv_d_ff;
            pcr_pkg::OFS_OMC_AB:    nxt_rdata = omc_ff[7:0];
            pcr_pkg::OFS_OMC_BC:    nxt_rdata = omc_ff[15:8];
            pcr_pkg::OFS_OMC_MASK_AB: nxt_rdata = omc_mask_ff[7:0];
            pcr_pkg::OFS_OMC_MASK_BC: nxt_rdata = omc_mask_ff[15:8];
            pcr_pkg::OFS_MEM_MAP:   nxt_rdata = mem_map_ff;
            default: ;
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= pcr_pkg::RD_UNMAPPED;
        end else if (rd) begin
            rdata_o <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            test_port_active_o <= 1'b0;
            periph_mode_o      <= 1'b0;
            addr_in_latched_o  <= 16'h0000;
            output_macrocell_o <= 16'h0000;
        end else if (clk_en_i) begin
            test_port_active_o <= test_on;
            periph_mode_o      <= periph_on & ~data_port;
            addr_in_latched_o  <= addr_lat_ff;
            output_macrocell_o <= omc_ff;
        end
    end

endmodule : pcr_ports

// [testbench/pcr_ports_chk.sv]
// checker: port relations of the programmable i/o port block
`timescale 1ns/10ps
module pcr_ports_chk (
    // clock, reset, enable
    input wire logic              mclk_i,
    input wire logic              reset_n_i,
    input wire logic              clk_en_i,
    // register bus
    input wire pcr_pkg::pcr_bus_t bus_i,
    input wire logic [7:0]        rdata_o,
    // mcu view and logic terms
    input wire logic              mcu_rd_cycle_i,
    input wire logic [7:0]        mcu_data_i,
    input wire logic [7:0]        mcu_data_o,
    input wire logic              data_port_cfg_i,
    input wire logic              test_port_cfg_i,
    input wire logic              jtag_enable_i,
    input wire logic              test_port_select_term_i,
    input wire logic              periph_select_term_0_i,
    input wire logic              periph_select_term_1_i,
    input wire logic [2:0]        array_oe_d_i,
    // pins and status
    input wire logic [7:0]        pin_a_i,
    input wire pcr_pkg::pcr_pin_t pin_a_o,
    input wire logic [2:0]        pin_d_o,
    input wire logic [2:0]        pin_d_oe_o,
    input wire logic [2:0]        pin_d_fast_o,
    input wire logic              test_port_active_o,
    input wire logic              periph_mode_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    logic wr_any;
    logic any_test;
    logic psel;
    logic pa_cyc;
    assign wr_any   = clk_en_i && bus_i.wr;
    assign any_test = test_port_cfg_i | jtag_enable_i
                      | test_port_select_term_i;
    assign psel     = periph_select_term_0_i | periph_select_term_1_i;
    // port a buffer cycle outside data-port use
    assign pa_cyc   = clk_en_i && !data_port_cfg_i;

    a_dir_d_oe: assert property (
        wr_any && bus_i.addr == pcr_pkg::OFS_DIR_D ##1 clk_en_i
        |=> pin_d_oe_o == ($past(bus_i.wdata[2:0], 2)
        | $past(array_oe_d_i))) else $error("port d enable wrong");
    a_drv_d_fast: assert property (
        wr_any && bus_i.addr == pcr_pkg::OFS_DRV_D ##1 clk_en_i
        |=> pin_d_fast_o == $past(bus_i.wdata[2:0], 2))
        else $error("port d slew select wrong");
    a_dout_d_pin: assert property (
        wr_any && bus_i.addr == pcr_pkg::OFS_DOUT_D ##1 clk_en_i
        |=> pin_d_o == $past(bus_i.wdata[2:0], 2))
        else $error("port d output level wrong");
    a_rd_dir_d: assert property (clk_en_i && bus_i.rd
        && bus_i.addr == pcr_pkg::OFS_DIR_D |=> rdata_o[7:3] == 5'h00)
        else $error("port d direction upper bits read nonzero");
    a_unmapped_rd: assert property (clk_en_i && bus_i.rd
        && bus_i.addr == 8'h30 |=> rdata_o == pcr_pkg::RD_UNMAPPED)
        else $error("unmapped read not zero");
    a_test_port: assert property (clk_en_i
        |=> test_port_active_o == $past(any_test))
        else $error("test port select wrong");
    a_periph_tristate: assert property (pa_cyc && !psel
        ##1 periph_mode_o |-> pin_a_o.oe == 8'h00)
        else $error("peripheral buffer driven without select");
    a_periph_write: assert property (pa_cyc && psel && !mcu_rd_cycle_i
        ##1 periph_mode_o |-> pin_a_o.oe == 8'hFF
        && pin_a_o.dout == $past(mcu_data_i)) else $error("periph write wrong");
    a_periph_read: assert property (pa_cyc && psel && mcu_rd_cycle_i
        ##1 periph_mode_o |-> pin_a_o.oe == 8'h00
        && mcu_data_o == $past(pin_a_i)) else $error("periph read wrong");
    a_data_port: assert property (clk_en_i && data_port_cfg_i
        && mcu_rd_cycle_i |=> mcu_data_o == $past(pin_a_i)
        && pin_a_o.oe == 8'h00) else $error("data port read wrong");
endmodule : pcr_ports_chk

// [testbench/pcr_host_model.sv]
// host mcu model: ordinary register read and write cycles
`timescale 1ns/10ps
module pcr_host_model (
    // clock and read data
    input  wire logic        mclk_i,
    input  wire logic [7:0]  rdata_i,
    // register bus
    output pcr_pkg::pcr_bus_t bus_o
);
    initial bus_o = '0;
    // released fields are inverted so a stale value never passes as held
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk_i);
        #1;
        bus_o = {1'b0, 1'b1, addr, data};
        @(posedge mclk_i);
        #1;
        bus_o = {2'b00, ~addr, ~data};
    endtask : write
    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk_i);
        #1;
        bus_o = {1'b1, 1'b0, addr, 8'h00};
        @(posedge mclk_i);
        #1;
        bus_o = {2'b00, ~addr, 8'hFF};
        data = rdata_i;
    endtask : read
endmodule : pcr_host_model

// [testbench/pcr_ports_tb_top.sv]
// testbench top: register and pin scenarios for the port block
`timescale 1ns/10ps
module pcr_ports_tb_top;
    logic mclk_i, reset_n_i, clk_en_i, mcu_rd_cycle_i, address_latch_strobe_i;
    logic data_port_cfg_i, test_port_cfg_i, jtag_enable_i;
    logic periph_select_term_0_i, periph_select_term_1_i;
    logic test_port_select_term_i, test_port_active_o, periph_mode_o;
    logic [15:0] mcu_addr_i, output_macrocell_d_i;
    logic [15:0] addr_in_latched_o, output_macrocell_o;
    logic [7:0] rdata_o, mcu_data_i, mcu_data_o, array_oe_a_i, array_oe_b_i;
    logic [7:0] array_oe_c_i, pin_a_i, pin_b_i, pin_c_i;
    logic [2:0] array_oe_d_i, pin_d_i, pin_d_o, pin_d_oe_o, pin_d_fast_o;
    logic [1:0] addr_map_sel_i;
    pcr_pkg::pcr_bus_t bus_i;
    pcr_pkg::pcr_pin_t pin_a_o, pin_b_o, pin_c_o;
    int errors, checks_done;
    logic [7:0] rw_ofs [13] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h14, 8'h08,
        8'h09, 8'h16, 8'h04, 8'h05, 8'h12, 8'h22, 8'h23};
    logic [7:0] b_out [4] = '{8'h34, 8'h34, 8'h02, 8'h12};

    pcr_host_model u_pcr_host_model (.mclk_i, .rdata_i(rdata_o),
        .bus_o(bus_i));
    pcr_ports u_pcr_ports (.mclk_i, .reset_n_i, .clk_en_i, .bus_i, .rdata_o,
        .mcu_addr_i, .mcu_data_i, .mcu_rd_cycle_i, .address_latch_strobe_i,
        .mcu_data_o, .addr_map_sel_i, .data_port_cfg_i, .test_port_cfg_i,
        .jtag_enable_i, .array_oe_a_i, .array_oe_b_i, .array_oe_c_i,
        .array_oe_d_i, .periph_select_term_0_i, .periph_select_term_1_i,
        .test_port_select_term_i, .output_macrocell_d_i, .pin_a_i, .pin_b_i,
        .pin_c_i, .pin_d_i, .pin_a_o, .pin_b_o, .pin_c_o, .pin_d_o, .pin_d_oe_o,
        .pin_d_fast_o, .test_port_active_o, .periph_mode_o, .addr_in_latched_o,
        .output_macrocell_o);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_pcr_host_model.write(a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_pcr_host_model.read(a, d);
        check(d, e);
    endtask : rd_chk
    // pins follow registers two edges after a write
    task automatic settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic end_of_test();
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // --------------------------------------------------------------
    // clock, watchdog, sequence
    // --------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        {reset_n_i, mcu_rd_cycle_i, address_latch_strobe_i, data_port_cfg_i,
         test_port_cfg_i, jtag_enable_i, periph_select_term_0_i,
         periph_select_term_1_i, test_port_select_term_i, mcu_addr_i,
         output_macrocell_d_i, mcu_data_i, array_oe_a_i, array_oe_b_i,
         array_oe_c_i, pin_a_i, pin_b_i, pin_c_i, array_oe_d_i, pin_d_i,
         addr_map_sel_i} = '0;
        clk_en_i = 1'b1;
        repeat (5) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd_chk(rw_ofs[i], 8'h00);
        end
        check(pin_a_o.oe, 8'h00);
        check({5'h00, pin_d_oe_o}, 8'h00);
        foreach (rw_ofs[i]) begin
            wr(rw_ofs[i], 8'hA5 ^ 8'(i));
            rd_chk(rw_ofs[i], 8'hA5 ^ 8'(i));
        end
        wr(pcr_pkg::OFS_DIR_D, 8'hFF);
        rd_chk(pcr_pkg::OFS_DIR_D, 8'h07);
        wr(pcr_pkg::OFS_MODE_A, 8'h00);
        wr(pcr_pkg::OFS_DIR_A, 8'h0F);
        wr(pcr_pkg::OFS_DOUT_A, 8'h5A);
        wr(pcr_pkg::OFS_DRV_A, 8'hF0);
        array_oe_a_i = 8'h30;
        settle();
        check(pin_a_o.oe, 8'h3F);
        check(pin_a_o.dout & 8'h3F, 8'h1A);
        check(pin_a_o.od, 8'hF0);
        check(pin_a_o.fast, 8'h00);
        wr(pcr_pkg::OFS_DRV_A, 8'h0F);
        wr(pcr_pkg::OFS_DRV_C, 8'hFF);
        wr(pcr_pkg::OFS_DIR_D, 8'h01);
        wr(pcr_pkg::OFS_DRV_D, 8'hFF);
        wr(pcr_pkg::OFS_DOUT_D, 8'hFE);
        array_oe_d_i = 3'h4;
        settle();
        check(pin_a_o.od, 8'h00);
        check(pin_a_o.fast, 8'h0F);
        check(pin_c_o.od, 8'hFF);
        check({2'h0, pin_d_fast_o, pin_d_oe_o}, 8'h3D);
        check({5'h00, pin_d_o}, 8'h06);
        mcu_addr_i = 16'h1234;
        address_latch_strobe_i = 1'b1;
        wr(pcr_pkg::OFS_MODE_A, 8'hFF);
        wr(pcr_pkg::OFS_MODE_B, 8'hFF);
        wr(pcr_pkg::OFS_DIR_A, 8'hFF);
        wr(pcr_pkg::OFS_DIR_B, 8'hFF);
        address_latch_strobe_i = 1'b0;
        clk_en_i = 1'b0;
        wr(pcr_pkg::OFS_DIR_B, 8'h55);
        clk_en_i = 1'b1;
        rd_chk(pcr_pkg::OFS_DIR_B, 8'hFF);
        for (int m = 0; m < 4; m++) begin
            addr_map_sel_i = 2'(m);
            settle();
            check(pin_b_o.dout, b_out[m]);
        end
        check(addr_in_latched_o[7:0], 8'h34);
        addr_map_sel_i = pcr_pkg::AMAP_GENERIC;
        wr(pcr_pkg::OFS_MODE_A, 8'h0F);
        wr(pcr_pkg::OFS_DOUT_A, 8'hC0);
        settle();
        check(pin_a_o.dout, 8'hC4);
        pin_b_i = 8'hC3;
        pin_c_i = 8'h3C;
        pin_d_i = 3'h5;
        rd_chk(pcr_pkg::OFS_DATA_IN_B, 8'hC3);
        rd_chk(pcr_pkg::OFS_DATA_IN_C, 8'h3C);
        rd_chk(pcr_pkg::OFS_DATA_IN_D, 8'h05);
        wr(pcr_pkg::OFS_OMC_MASK_AB, 8'h00);
        output_macrocell_d_i = 16'hBEEF;
        settle();
        rd_chk(pcr_pkg::OFS_OMC_AB, 8'hEF);
        rd_chk(pcr_pkg::OFS_OMC_BC, 8'hBE);
        wr(pcr_pkg::OFS_OMC_AB, 8'h12);
        @(posedge mclk_i);
        #1;
        check(output_macrocell_o[7:0], 8'h12);
        wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        wr(pcr_pkg::OFS_DIR_C, 8'hFF);
        for (int s = 0; s < 3; s++) begin
            {test_port_select_term_i, jtag_enable_i, test_port_cfg_i} =
                3'(1 << s);
            settle();
            check({test_port_active_o, pin_c_o.oe[6:0]}, 8'h80);
        end
        {test_port_select_term_i, jtag_enable_i, test_port_cfg_i} = 3'h0;
        settle();
        check(pin_c_o.oe, 8'hFF);
        wr(pcr_pkg::OFS_DIR_A, 8'h00);
        wr(pcr_pkg::OFS_MEM_MAP, 8'h80);
        settle();
        check({periph_mode_o, pin_a_o.oe[6:0]}, 8'h80);
        periph_select_term_0_i = 1'b1;
        mcu_data_i = 8'h69;
        settle();
        check(pin_a_o.oe & pin_a_o.dout, 8'h69);
        {periph_select_term_0_i, periph_select_term_1_i} = 2'b01;
        mcu_rd_cycle_i = 1'b1;
        pin_a_i = 8'h96;
        settle();
        check(mcu_data_o | pin_a_o.oe, 8'h96);
        periph_select_term_1_i = 1'b0;
        wr(pcr_pkg::OFS_MEM_MAP, 8'h00);
        data_port_cfg_i = 1'b1;
        pin_a_i = 8'hA7;
        settle();
        check(mcu_data_o, 8'hA7);
        mcu_rd_cycle_i = 1'b0;
        mcu_data_i = 8'h3E;
        settle();
        check(pin_a_o.dout, 8'h3E);
        end_of_test();
    end
endmodule : pcr_ports_tb_top

bind pcr_ports pcr_ports_chk u_pcr_ports_chk (.mclk_i, .reset_n_i, .clk_en_i,
    .bus_i, .rdata_o, .mcu_rd_cycle_i, .mcu_data_i, .mcu_data_o,
    .data_port_cfg_i, .test_port_cfg_i, .jtag_enable_i,
    .test_port_select_term_i, .periph_select_term_0_i, .periph_select_term_1_i,
    .array_oe_d_i, .pin_a_i, .pin_a_o, .pin_d_o, .pin_d_oe_o, .pin_d_fast_o,
    .test_port_active_o, .periph_mode_o);
